//--- src/mrd_lock_timer.sv
`timescale 1ns/100ps
module mrd_lock_timer #(
	parameter int LOCK_CK = mrd_pkg::MRD_LOCK_CK
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic start,
	input wire logic loop_on,
	input wire logic ck_edge,
	// Status
	output mrd_pkg::mrd_lock_t state,
	output logic locked
);
	localparam logic [mrd_pkg::MRD_LOCK_W-1:0] LAST = mrd_pkg::MRD_LOCK_W'(LOCK_CK - 1);

	mrd_pkg::mrd_lock_t state_q;
	logic [mrd_pkg::MRD_LOCK_W-1:0] cnt_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= mrd_pkg::MRD_LK_OFF;
		end else if (!loop_on) begin
			state_q <= mrd_pkg::MRD_LK_OFF;
		end else begin
			unique case (state_q)
				mrd_pkg::MRD_LK_OFF: begin
					if (start) begin
						state_q <= mrd_pkg::MRD_LK_RUN;
					end
				end
				mrd_pkg::MRD_LK_RUN: begin
					if (start) begin
						state_q <= mrd_pkg::MRD_LK_RUN;
					end else if (ck_edge && cnt_q == LAST) begin
						state_q <= mrd_pkg::MRD_LK_DONE;
					end
				end
				mrd_pkg::MRD_LK_DONE: begin
					if (start) begin
						state_q <= mrd_pkg::MRD_LK_RUN;
					end
				end
				default: state_q <= mrd_pkg::MRD_LK_OFF;
			endcase
		end
	end

	// Counts link clock edges, restarts on every loop reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (start || state_q != mrd_pkg::MRD_LK_RUN) begin
			cnt_q <= '0;
		end else if (ck_edge) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	assign state = state_q;
	assign locked = (state_q == mrd_pkg::MRD_LK_DONE);
endmodule

//--- src/mrd_mode_reg_one.sv
`timescale 1ns/100ps
// Function
// - Auto precharge write delay: recovery plus precharge
// - Mask and CRC on: bad CRC blocks write
// - Read-to-precharge plus precharge gates same-bank activate
// - Loop reset bit clears itself after reset
// - Mode write: select and strobes low, act high, bits from group/bank/address
// - Bits 20:18 select register; 111 unused
// - Bit 12 disables driver and output termination
// - Bit 11 enables extra termination strobe, byte-wide
// - Bits 10:8 decode nominal termination ohms
// - Bits 4:3 added latency; 01 barred gear-down
// - Bits 2:1 decode driver strength ohms
// - Bit 0 enables delay-locked loop
// - Loop off in self refresh, back after
// - Writes need loop only with write termination
module mrd_mode_reg_one #(
	parameter int LOCK_CK = mrd_pkg::MRD_LOCK_CK,
	parameter bit BYTE_WIDE = 1'b1
) (
	// Clocks and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic CK,
	// Command pins
	input wire logic CS_N,
	input wire logic ACT_N,
	input wire logic RAS_N,
	input wire logic CAS_N,
	input wire logic WE_N,
	input wire logic [1:0] BG,
	input wire logic [1:0] BA,
	input wire logic [17:0] A,
	// Device state from neighbouring logic
	input wire logic SELF_REFRESH,
	input wire logic GEAR_DOWN,
	input wire logic [5:0] COLUMN_LATENCY,
	input wire logic [5:0] WRITE_RECOVERY_CYCLES,
	input wire logic [5:0] READ_TO_PRECHARGE_CYCLES,
	input wire logic [5:0] PRECHARGE_PERIOD,
	input wire logic WRITE_TERMINATION_EN,
	// Write path
	input wire logic WRITE_BYTE_MASK_EN,
	input wire logic WRITE_CRC_EN,
	input wire logic WR_DATA_VALID,
	input wire logic WR_CRC_ERR,
	output logic ARRAY_WRITE,
	output logic WRITE_DISCARDED,
	// Timing results
	output logic [6:0] AUTOPRECHARGE_WRITE_DELAY,
	output logic [6:0] ACT_AFTER_READ_DELAY,
	output logic [5:0] ADDED_LATENCY,
	// Decoded mode
	output logic OUTPUT_DRIVE_EN,
	output logic OUTPUT_TERM_EN,
	output logic EXTRA_TERMINATION_STROBE,
	output logic [7:0] NOMINAL_TERMINATION,
	output logic [7:0] DRIVER_STRENGTH,
	output logic WRITE_LEVELING,
	output logic MODE_FAULT,
	// Loop status
	output logic LOOP_ON,
	output logic LOOP_RESET,
	output logic LOOP_LOCKED,
	output logic WRITE_TERM_BLOCKED
);
	// Nominal termination ohms for a code
	function automatic logic [7:0] nom_ohm(input logic [2:0] code);
		unique case (code)
			3'h0: nom_ohm = mrd_pkg::MRD_OHM_OFF;
			3'h1: nom_ohm = 8'h3c;
			3'h2: nom_ohm = 8'h78;
			3'h3: nom_ohm = 8'h28;
			3'h4: nom_ohm = 8'hf0;
			3'h5: nom_ohm = 8'h30;
			3'h6: nom_ohm = 8'h50;
			3'h7: nom_ohm = 8'h22;
		endcase
	endfunction

	// Driver ohms; reserved 11 reads as zero
	function automatic logic [7:0] drv_ohm(input logic [1:0] code);
		unique case (code)
			mrd_pkg::MRD_DRV_34: drv_ohm = 8'h22;
			mrd_pkg::MRD_DRV_48: drv_ohm = 8'h30;
			mrd_pkg::MRD_DRV_40: drv_ohm = 8'h28;
			default: drv_ohm = mrd_pkg::MRD_OHM_OFF;
		endcase
	endfunction

	// Two-flop synchronisers for all pins
	mrd_pkg::mrd_cmd_t pin_raw, pin_s1_q, pin_s2_q, cmd_q;
	logic ck_s1_q, ck_s2_q, ck_s3_q, ck_rise;
	assign pin_raw = '{cs_n: CS_N, act_n: ACT_N, ras_n: RAS_N, cas_n: CAS_N, we_n: WE_N,
		bg: BG, ba: BA, a: A};

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			pin_s1_q <= '1;
			pin_s2_q <= '1;
			ck_s1_q <= 1'b0;
			ck_s2_q <= 1'b0;
			ck_s3_q <= 1'b0;
		end else begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
			ck_s1_q <= CK;
			ck_s2_q <= ck_s1_q;
			ck_s3_q <= ck_s2_q;
		end
	end
	assign ck_rise = ck_s2_q && !ck_s3_q;

	// Command valid for one cycle after each link clock rise
	logic cmd_v_q;
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			cmd_q <= '1;
			cmd_v_q <= 1'b0;
		end else begin
			cmd_v_q <= ck_rise;
			if (ck_rise) begin
				cmd_q <= pin_s2_q;
			end
		end
	end

	// Mode write: select, act high, three strobes low
	logic mode_reg_write_cmd, mrs_one, mrs_zero;
	logic [mrd_pkg::MRD_REG_W-1:0] word;
	logic [2:0] sel;
	assign mode_reg_write_cmd = cmd_v_q && !cmd_q.cs_n && cmd_q.act_n && !cmd_q.ras_n && !cmd_q.cas_n
		&& !cmd_q.we_n;
	assign word = {cmd_q.bg, cmd_q.ba, cmd_q.a};
	assign sel = word[mrd_pkg::MRD_SEL_HI:mrd_pkg::MRD_SEL_LO];
	assign mrs_one = mode_reg_write_cmd && sel == mrd_pkg::MRD_SEL_ONE;
	assign mrs_zero = mode_reg_write_cmd && sel == mrd_pkg::MRD_SEL_ZERO;

	// Mode register one; bits 16:14 are not pinned and not kept
	mrd_pkg::mrd_fields_t f_q;
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			f_q <= mrd_pkg::MRD_FIELDS_RST;
		end else if (mrs_one) begin
			f_q.out_off <= word[mrd_pkg::MRD_QOFF];
			f_q.strobe_term <= word[mrd_pkg::MRD_EXTRA_TERMINATION_STROBE];
			f_q.nom_term <= word[mrd_pkg::MRD_NOM_HI:mrd_pkg::MRD_NOM_LO];
			f_q.write_level <= word[mrd_pkg::MRD_WLEV];
			f_q.rx_eq <= {word[mrd_pkg::MRD_EQ_HI], word[mrd_pkg::MRD_EQ_MID],
				word[mrd_pkg::MRD_EQ_LO]};
			f_q.added_lat <= word[mrd_pkg::MRD_AL_HI:mrd_pkg::MRD_AL_LO];
			f_q.drive <= word[mrd_pkg::MRD_DRV_HI:mrd_pkg::MRD_DRV_LO];
			f_q.dll_en <= word[mrd_pkg::MRD_DLL];
		end
	end

	// Reserved bits and illegal select are flagged, not obeyed
	logic fault_q;
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			fault_q <= 1'b0;
		end else if (mode_reg_write_cmd) begin
			fault_q <= sel == mrd_pkg::MRD_SEL_BAD
				|| (mrs_one && (word[mrd_pkg::MRD_RFU_HI] || word[mrd_pkg::MRD_RFU_LO]
				|| word[mrd_pkg::MRD_EQ_HI] || word[mrd_pkg::MRD_EQ_MID]
				|| word[mrd_pkg::MRD_EQ_LO]));
		end
	end

	// Loop reset bit: set by mode write zero, cleared next cycle
	logic loop_rst_q, loop_on;
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			loop_rst_q <= 1'b0;
		end else begin
			loop_rst_q <= mrs_zero && word[mrd_pkg::MRD_DLL_RST];
		end
	end

	// Self refresh stops the loop; lock restarts when it ends
	logic sr_q, sr_exit;
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			sr_q <= 1'b0;
		end else begin
			sr_q <= SELF_REFRESH;
		end
	end
	assign sr_exit = sr_q && !SELF_REFRESH;
	assign loop_on = f_q.dll_en && !SELF_REFRESH;

	mrd_pkg::mrd_lock_t lk_state;
	logic locked;
	mrd_lock_timer #(.LOCK_CK(LOCK_CK)) u_lock (
		.clk(CLK_SYS),
		.rst(RST),
		.start(loop_rst_q || (sr_exit && f_q.dll_en)),
		.loop_on(loop_on),
		.ck_edge(ck_rise),
		.state(lk_state),
		.locked(locked)
	);

	// Write path: mask with CRC stores only after a clean check
	logic block;
	assign block = WRITE_BYTE_MASK_EN && WRITE_CRC_EN && WR_CRC_ERR;
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			ARRAY_WRITE <= 1'b0;
			WRITE_DISCARDED <= 1'b0;
		end else begin
			ARRAY_WRITE <= WR_DATA_VALID && !block;
			WRITE_DISCARDED <= WR_DATA_VALID && block;
		end
	end

	// Delays; 7 bits hold any sum of two 6-bit counts
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			AUTOPRECHARGE_WRITE_DELAY <= '0;
			ACT_AFTER_READ_DELAY <= '0;
		end else begin
			AUTOPRECHARGE_WRITE_DELAY <= {1'b0, WRITE_RECOVERY_CYCLES}
				+ {1'b0, PRECHARGE_PERIOD};
			ACT_AFTER_READ_DELAY <= {1'b0, READ_TO_PRECHARGE_CYCLES}
				+ {1'b0, PRECHARGE_PERIOD};
		end
	end

	// Added latency; reserved code gives none
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			ADDED_LATENCY <= '0;
		end else begin
			unique case (f_q.added_lat)
				mrd_pkg::MRD_AL_M1: ADDED_LATENCY <= COLUMN_LATENCY - mrd_pkg::MRD_ONE;
				mrd_pkg::MRD_AL_M2: ADDED_LATENCY <= COLUMN_LATENCY - mrd_pkg::MRD_TWO;
				default: ADDED_LATENCY <= '0;
			endcase
		end
	end

	// Decoded outputs, registered
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			OUTPUT_DRIVE_EN <= 1'b1;
			OUTPUT_TERM_EN <= 1'b1;
			EXTRA_TERMINATION_STROBE <= 1'b0;
			NOMINAL_TERMINATION <= mrd_pkg::MRD_OHM_OFF;
			DRIVER_STRENGTH <= mrd_pkg::MRD_OHM_OFF;
			WRITE_LEVELING <= 1'b0;
			MODE_FAULT <= 1'b0;
			WRITE_TERM_BLOCKED <= 1'b0;
		end else begin
			OUTPUT_DRIVE_EN <= !f_q.out_off;
			OUTPUT_TERM_EN <= !f_q.out_off;
			EXTRA_TERMINATION_STROBE <= f_q.strobe_term && BYTE_WIDE;
			NOMINAL_TERMINATION <= nom_ohm(f_q.nom_term);
			DRIVER_STRENGTH <= drv_ohm(f_q.drive);
			WRITE_LEVELING <= f_q.write_level;
			// Gear-down with minus-one latency is a mode fault
			MODE_FAULT <= fault_q || (GEAR_DOWN && f_q.added_lat == mrd_pkg::MRD_AL_M1);
			// Writes proceed without lock unless write termination is on
			WRITE_TERM_BLOCKED <= WRITE_TERMINATION_EN && !locked;
		end
	end

	assign LOOP_ON = loop_on;
	assign LOOP_RESET = loop_rst_q;
	assign LOOP_LOCKED = locked && lk_state == mrd_pkg::MRD_LK_DONE;
endmodule

//--- src/mrd_pkg.sv
package mrd_pkg;
	// Command and address pins sampled together
	typedef struct packed {
		logic cs_n;
		logic act_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [1:0] bg;
		logic [1:0] ba;
		logic [17:0] a;
	} mrd_cmd_t;

	typedef struct packed {
		logic out_off;
		logic strobe_term;
		logic [2:0] nom_term;
		logic write_level;
		logic [2:0] rx_eq;
		logic [1:0] added_lat;
		logic [1:0] drive;
		logic dll_en;
	} mrd_fields_t;

	typedef enum logic [1:0] {
		MRD_LK_OFF = 2'h0,
		MRD_LK_RUN = 2'h1,
		MRD_LK_DONE = 2'h3
	} mrd_lock_t;

	localparam int MRD_REG_W = 22;
	localparam int MRD_RFU_HI = 21;
	localparam int MRD_RFU_LO = 17;
	localparam int MRD_SEL_HI = 20;
	localparam int MRD_SEL_LO = 18;
	localparam int MRD_EQ_HI = 13;
	localparam int MRD_QOFF = 12;
	localparam int MRD_EXTRA_TERMINATION_STROBE = 11;
	localparam int MRD_NOM_HI = 10;
	localparam int MRD_NOM_LO = 8;
	localparam int MRD_WLEV = 7;
	localparam int MRD_EQ_MID = 6;
	localparam int MRD_EQ_LO = 5;
	localparam int MRD_AL_HI = 4;
	localparam int MRD_AL_LO = 3;
	localparam int MRD_DRV_HI = 2;
	localparam int MRD_DRV_LO = 1;
	localparam int MRD_DLL = 0;
	localparam int MRD_DLL_RST = 8;

	localparam logic [2:0] MRD_SEL_ZERO = 3'h0;
	localparam logic [2:0] MRD_SEL_ONE = 3'h1;
	localparam logic [2:0] MRD_SEL_BAD = 3'h7;
	localparam logic [1:0] MRD_AL_OFF = 2'h0;
	localparam logic [1:0] MRD_AL_M1 = 2'h1;
	localparam logic [1:0] MRD_AL_M2 = 2'h2;
	localparam logic [1:0] MRD_DRV_34 = 2'h0;
	localparam logic [1:0] MRD_DRV_48 = 2'h1;
	localparam logic [1:0] MRD_DRV_40 = 2'h2;
	localparam logic [5:0] MRD_ONE = 6'h01;
	localparam logic [5:0] MRD_TWO = 6'h02;
	localparam logic [7:0] MRD_OHM_OFF = 8'h00;

	// Reset value: loop on, all else normal
	localparam mrd_fields_t MRD_FIELDS_RST = '{
		out_off: 1'b0, strobe_term: 1'b0, nom_term: 3'h0, write_level: 1'b0,
		rx_eq: 3'h0, added_lat: 2'h0, drive: 2'h0, dll_en: 1'b1};

	// Lock time in link clock cycles; value is a plain default
	localparam int MRD_LOCK_CK = 768;
	localparam int MRD_LOCK_W = 16;
endpackage

//--- tb/mrd_ctrl_model.sv
`timescale 1ns/100ps
module mrd_ctrl_model (
	// Request
	input wire logic go,
	input wire logic mode_reg_write_cmd,
	input wire logic [21:0] word,
	// Pins
	output logic ck,
	output mrd_pkg::mrd_cmd_t cmd,
	output logic done
);
	// Clock runs free: the loop needs edges to lock
	initial begin
		cmd = '1;
		done = 1'b0;
		ck = 1'b0;
		#137;
		forever #400 ck = ~ck;
	end
	// Set on the fall, held over the rise; row pins low for a mode write
	always @(negedge ck) begin
		if (go && !done) begin
			cmd <= {1'b0, 1'b1, ~mode_reg_write_cmd, 2'b00, word[21:17], ~cmd.a[16:14], word[13:0]};
			done <= 1'b1;
		end else begin
			cmd <= {1'b1, ~cmd[25:0]};
			if (!go) done <= 1'b0;
		end
	end
endmodule

//--- tb/mrd_mode_reg_one_assertions.sv
`timescale 1ns/100ps
module mrd_mode_reg_one_assertions (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// Inputs
	input wire logic SELF_REFRESH,
	input wire logic [5:0] WRITE_RECOVERY_CYCLES,
	input wire logic [5:0] READ_TO_PRECHARGE_CYCLES,
	input wire logic [5:0] PRECHARGE_PERIOD,
	input wire logic WRITE_TERMINATION_EN,
	input wire logic WRITE_BYTE_MASK_EN,
	input wire logic WRITE_CRC_EN,
	input wire logic WR_DATA_VALID,
	input wire logic WR_CRC_ERR,
	// Outputs
	input wire logic ARRAY_WRITE,
	input wire logic WRITE_DISCARDED,
	input wire logic [6:0] AUTOPRECHARGE_WRITE_DELAY,
	input wire logic [6:0] ACT_AFTER_READ_DELAY,
	input wire logic OUTPUT_DRIVE_EN,
	input wire logic OUTPUT_TERM_EN,
	input wire logic LOOP_ON,
	input wire logic LOOP_RESET,
	input wire logic LOOP_LOCKED,
	input wire logic WRITE_TERM_BLOCKED
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	wire logic ok_word = WR_DATA_VALID & ~(WRITE_BYTE_MASK_EN & WRITE_CRC_EN & WR_CRC_ERR);
	wire logic bad_word = WR_DATA_VALID & WRITE_BYTE_MASK_EN & WRITE_CRC_EN & WR_CRC_ERR;
	chk_wr_delay_sum: assert property (1 |=> AUTOPRECHARGE_WRITE_DELAY ==
		7'($past(WRITE_RECOVERY_CYCLES)) + 7'($past(PRECHARGE_PERIOD))) else $error("wr sum");
	chk_rtp_delay_sum: assert property (1 |=> ACT_AFTER_READ_DELAY ==
		7'($past(READ_TO_PRECHARGE_CYCLES)) + 7'($past(PRECHARGE_PERIOD))) else $error("rtp sum");
	chk_crc_blocks: assert property (bad_word |=> WRITE_DISCARDED && !ARRAY_WRITE)
		else $error("bad word stored");
	chk_good_stored: assert property (ok_word |=> ARRAY_WRITE && !WRITE_DISCARDED)
		else $error("good word lost");
	chk_reset_clears: assert property (LOOP_RESET |=> !LOOP_RESET)
		else $error("loop reset stuck");
	chk_lock_restart: assert property (LOOP_RESET |-> ##2 !LOOP_LOCKED)
		else $error("lock kept over reset");
	chk_refresh_off: assert property (SELF_REFRESH |-> !LOOP_ON)
		else $error("loop on in refresh");
	chk_qoff_pair: assert property (OUTPUT_DRIVE_EN == OUTPUT_TERM_EN)
		else $error("drive and term differ");
	chk_wterm_idle: assert property (!WRITE_TERMINATION_EN |=> !WRITE_TERM_BLOCKED)
		else $error("blocked without wterm");
	chk_wterm_locked: assert property (LOOP_LOCKED [*2] |-> !WRITE_TERM_BLOCKED)
		else $error("blocked while locked");
	cover property (bad_word);
	cover property (LOOP_RESET);
	cover property ($rose(LOOP_LOCKED));
endmodule
bind mrd_mode_reg_one mrd_mode_reg_one_assertions chk_u (.CLK_SYS, .RST, .SELF_REFRESH,
	.WRITE_RECOVERY_CYCLES, .READ_TO_PRECHARGE_CYCLES, .PRECHARGE_PERIOD,
	.WRITE_TERMINATION_EN, .WRITE_BYTE_MASK_EN, .WRITE_CRC_EN, .WR_DATA_VALID, .WR_CRC_ERR,
	.ARRAY_WRITE, .WRITE_DISCARDED, .AUTOPRECHARGE_WRITE_DELAY, .ACT_AFTER_READ_DELAY,
	.OUTPUT_DRIVE_EN, .OUTPUT_TERM_EN, .LOOP_ON, .LOOP_RESET, .LOOP_LOCKED, .WRITE_TERM_BLOCKED);

//--- tb/mrd_mode_reg_one_tb_top.sv
`timescale 1ns/100ps
module mrd_mode_reg_one_tb_top;
	logic CLK_SYS, RST, CK, SELF_REFRESH, GEAR_DOWN, WRITE_TERMINATION_EN, go, mode_reg_write_cmd, done;
	logic WRITE_BYTE_MASK_EN, WRITE_CRC_EN, WR_DATA_VALID, WR_CRC_ERR, ARRAY_WRITE;
	logic WRITE_DISCARDED, OUTPUT_DRIVE_EN, OUTPUT_TERM_EN, EXTRA_TERMINATION_STROBE;
	logic WRITE_LEVELING, MODE_FAULT, LOOP_ON, LOOP_RESET, LOOP_LOCKED, WRITE_TERM_BLOCKED, blk;
	logic [5:0] COLUMN_LATENCY, WRITE_RECOVERY_CYCLES, READ_TO_PRECHARGE_CYCLES, PRECHARGE_PERIOD;
	logic [6:0] AUTOPRECHARGE_WRITE_DELAY, ACT_AFTER_READ_DELAY;
	logic [5:0] ADDED_LATENCY;
	logic [7:0] NOMINAL_TERMINATION, DRIVER_STRENGTH;
	logic [21:0] word;
	logic [13:0] f;
	logic [31:0] rnd = 32'h0001_7f3c;
	mrd_pkg::mrd_cmd_t cmd;
	int miscompares = 0;
	int n_tests = 0;
	mrd_ctrl_model ctl_u (.go, .mode_reg_write_cmd, .word, .ck(CK), .cmd, .done);
	// Short lock count keeps the run brief
	mrd_mode_reg_one #(.LOCK_CK(4)) dut_u (.CLK_SYS, .RST, .CK, .CS_N(cmd.cs_n),
		.ACT_N(cmd.act_n), .RAS_N(cmd.ras_n), .CAS_N(cmd.cas_n), .WE_N(cmd.we_n), .BG(cmd.bg),
		.BA(cmd.ba), .A(cmd.a), .SELF_REFRESH, .GEAR_DOWN, .COLUMN_LATENCY,
		.WRITE_RECOVERY_CYCLES, .READ_TO_PRECHARGE_CYCLES, .PRECHARGE_PERIOD,
		.WRITE_TERMINATION_EN, .WRITE_BYTE_MASK_EN, .WRITE_CRC_EN, .WR_DATA_VALID, .WR_CRC_ERR,
		.ARRAY_WRITE, .WRITE_DISCARDED, .AUTOPRECHARGE_WRITE_DELAY, .ACT_AFTER_READ_DELAY,
		.ADDED_LATENCY, .OUTPUT_DRIVE_EN, .OUTPUT_TERM_EN, .EXTRA_TERMINATION_STROBE,
		.NOMINAL_TERMINATION, .DRIVER_STRENGTH, .WRITE_LEVELING, .MODE_FAULT, .LOOP_ON,
		.LOOP_RESET, .LOOP_LOCKED, .WRITE_TERM_BLOCKED);
	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [7:0] nom_ohm(logic [2:0] c);
		logic [7:0] t [8];
		t = '{8'h00, 8'h3c, 8'h78, 8'h28, 8'hf0, 8'h30, 8'h50, 8'h22};
		return t[c];
	endfunction
	function automatic logic [7:0] drv_ohm(logic [1:0] c);
		return c == 2'h0 ? 8'h22 : c == 2'h1 ? 8'h30 : c == 2'h2 ? 8'h28 : 8'h00;
	endfunction
	function automatic logic [7:0] al_cyc(logic [1:0] c, logic [5:0] cl);
		return c == 2'h1 ? {2'h0, cl} - 8'h01 : c == 2'h2 ? {2'h0, cl} - 8'h02 : 8'h00;
	endfunction
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk_val(string n, logic [7:0] e, logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_bit(string n, logic e, logic g);
		chk_val(n, {7'h00, e}, {7'h00, g});
	endtask
	// Hand a command to the controller, then let it reach the outputs
	task automatic send(logic [21:0] w, logic m);
		int n;
		n = 0;
		@(posedge CLK_SYS);
		word <= w;
		mode_reg_write_cmd <= m;
		go <= 1'b1;
		while (done !== 1'b1 && n < 40) begin
			@(posedge CLK_SYS);
			n++;
		end
		go <= 1'b0;
		if (n >= 40) miscompares++;
		repeat (16) @(posedge CLK_SYS);
		@(negedge CLK_SYS);
	endtask
	task automatic wait_lock();
		int n;
		n = 0;
		while (LOOP_LOCKED !== 1'b1 && n < 200) begin
			@(negedge CLK_SYS);
			n++;
		end
		chk_bit("lock_slow", 1'b1, n > 12);
		chk_bit("locked", 1'b1, LOOP_LOCKED);
	endtask
	initial begin
		CLK_SYS = 1'b0;
		forever #50 CLK_SYS = ~CLK_SYS;
	end
	initial begin
		repeat (20000) @(posedge CLK_SYS);
		miscompares++;
		test_done();
	end
	initial begin
		{RST, SELF_REFRESH, GEAR_DOWN, WRITE_TERMINATION_EN, go, mode_reg_write_cmd, word} = {1'b1, 27'h0};
		{WRITE_BYTE_MASK_EN, WRITE_CRC_EN, WR_DATA_VALID, WR_CRC_ERR} = 4'h0;
		{COLUMN_LATENCY, WRITE_RECOVERY_CYCLES} = 12'h410;
		{READ_TO_PRECHARGE_CYCLES, PRECHARGE_PERIOD} = 12'h208;
		repeat (16) @(posedge CLK_SYS);
		RST <= 1'b0;
		@(negedge CLK_SYS);
		chk_bit("drive_en", 1'b1, OUTPUT_DRIVE_EN);
		chk_bit("loop_on", 1'b1, LOOP_ON);
		for (int i = 0; i < 16; i++) begin
			rnd = lfsr(rnd);
			// Equaliser and reserved bits zero; loop off only with termination off
			f = {1'b0, rnd[12:11], i[2:0], rnd[7], 2'b00, i[1:0], i[3:2], 1'b0};
			f[0] = (i[2:0] != 3'h0) | rnd[0];
			@(posedge CLK_SYS);
			COLUMN_LATENCY <= {2'b01, rnd[17:14]};
			send({4'h1, 4'h0, f}, 1'b1);
			chk_val("nominal", nom_ohm(f[10:8]), NOMINAL_TERMINATION);
			chk_val("driver", drv_ohm(f[2:1]), DRIVER_STRENGTH);
			chk_val("added", al_cyc(f[4:3], COLUMN_LATENCY), {2'h0, ADDED_LATENCY});
			chk_bit("drive_en", !f[12], OUTPUT_DRIVE_EN);
			chk_bit("term_en", !f[12], OUTPUT_TERM_EN);
			chk_bit("strobe", f[11], EXTRA_TERMINATION_STROBE);
			chk_bit("leveling", f[7], WRITE_LEVELING);
			chk_bit("loop_on", f[0], LOOP_ON);
			chk_bit("fault", 1'b0, MODE_FAULT);
		end
		send({4'h7, 4'h0, ~f}, 1'b1);
		chk_bit("fault", 1'b1, MODE_FAULT);
		chk_val("nominal", nom_ohm(f[10:8]), NOMINAL_TERMINATION);
		send({4'h1, 4'h0, ~f}, 1'b0);
		chk_val("nominal", nom_ohm(f[10:8]), NOMINAL_TERMINATION);
		send({4'h9, 4'h0, f}, 1'b1);
		chk_bit("fault", 1'b1, MODE_FAULT);
		@(posedge CLK_SYS);
		GEAR_DOWN <= 1'b1;
		send({4'h1, 4'h0, 14'h0009}, 1'b1);
		chk_bit("fault", 1'b1, MODE_FAULT);
		@(posedge CLK_SYS);
		{GEAR_DOWN, WRITE_TERMINATION_EN} <= 2'b01;
		// Loop was just enabled, so reset it and wait for lock
		send({4'h0, 4'h0, 14'h0100}, 1'b1);
		chk_bit("locked", 1'b0, LOOP_LOCKED);
		chk_bit("blocked", 1'b1, WRITE_TERM_BLOCKED);
		wait_lock();
		@(negedge CLK_SYS);
		chk_bit("blocked", 1'b0, WRITE_TERM_BLOCKED);
		@(posedge CLK_SYS);
		SELF_REFRESH <= 1'b1;
		@(negedge CLK_SYS);
		chk_bit("loop_on", 1'b0, LOOP_ON);
		@(posedge CLK_SYS);
		SELF_REFRESH <= 1'b0;
		@(negedge CLK_SYS);
		chk_bit("loop_on", 1'b1, LOOP_ON);
		wait_lock();
		for (int i = 0; i < 40; i++) begin
			@(posedge CLK_SYS);
			rnd = lfsr(rnd);
			{WR_DATA_VALID, WR_CRC_ERR, WRITE_BYTE_MASK_EN, WRITE_CRC_EN} <= i < 3 ? 4'hf : rnd[3:0];
			// Values stand for cycles already rounded up from the times
			WRITE_RECOVERY_CYCLES <= rnd[9:4];
			READ_TO_PRECHARGE_CYCLES <= rnd[15:10];
			PRECHARGE_PERIOD <= rnd[21:16];
			@(posedge CLK_SYS);
			WR_DATA_VALID <= 1'b0;
			@(negedge CLK_SYS);
			blk = WR_CRC_ERR & WRITE_BYTE_MASK_EN & WRITE_CRC_EN;
			// First words are forced valid with mask and CRC on
			chk_bit("array_write", (rnd[3] | (i < 3)) & !blk, ARRAY_WRITE);
			chk_bit("discarded", (rnd[3] | (i < 3)) & blk, WRITE_DISCARDED);
			chk_val("wr_delay", {2'h0, rnd[9:4]} + {2'h0, rnd[21:16]},
				{1'b0, AUTOPRECHARGE_WRITE_DELAY});
			chk_val("act_delay", {2'h0, rnd[15:10]} + {2'h0, rnd[21:16]},
				{1'b0, ACT_AFTER_READ_DELAY});
		end
		test_done();
	end
endmodule
